// ===== shared/irm_regs.svh
`ifndef IRM_REGS_SVH
`define IRM_REGS_SVH

// fixed context count and bus geometry
`define IRM_NCTX        4
`define IRM_CTX_IDX_W   2
`define IRM_ADDR_W      8

// global register byte addresses
`define IRM_MASK_HI_SET 8'h00
`define IRM_MASK_HI_CLR 8'h04
`define IRM_MASK_LO_SET 8'h08
`define IRM_MASK_LO_CLR 8'h0c
`define IRM_IRQ_FLAGS   8'h10
`define IRM_IRQ_ENABLES 8'h14
`define IRM_TOP_FLAGS   8'h18

// per-context window: addr[7:6] == 01, ctx in addr[5:4], reg in addr[3:2]
`define IRM_CTX_WIN     2'b01
`define IRM_CTX_CONTROL 2'b00
`define IRM_CTX_MATCH   2'b01

// receive_context_match fields
`define IRM_M_LABEL     31:28
`define IRM_M_CMP       26:12
`define IRM_M_SYNC      11:8
`define IRM_M_CHAN      5:0

// context control fields
`define IRM_C_RUN       0
`define IRM_C_ARM       1
`define IRM_C_CHSET     2
`define IRM_C_FILL      3
`define IRM_C_HDR       4
`define IRM_C_ACTIVE    8

// top_irq_flags fields
`define IRM_T_RX_SUM    0
`define IRM_T_MISMATCH  1

// reset values and codes
`define IRM_CTL_RST     5'h00
`define IRM_MATCH_RST   32'h0000_0000
`define IRM_HOLD_SYNC   2'b11
`define IRM_RESP_OKAY   2'b00
`define IRM_RESP_SLVERR 2'b10

`endif

// ===== shared/irm_pkg.sv
package irm_pkg;

    typedef enum logic [1:0] {
        IRM_IDLE,
        IRM_ARMED,
        IRM_ACTIVE
    } irm_ctx_state_e;

    typedef logic [14:0] irm_cycle_t;
    typedef logic [5:0]  irm_chan_t;

endpackage

// ===== verilog/irm_ctx_match.sv
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "irm_regs.svh"
// Contract
// RULE1: each label enable admits its 2-bit code
// RULE2: labels always checked; sync only on hold 11
// RULE3: hold 11 waits for matching sync packet
// RULE4: wrong sync during hold is discarded
// RULE5: compare value is seconds[1:0] over cycle
// RULE6: armed context starts on cycle match, clears arm
// RULE7: single-channel context takes its channel only
// RULE8: no label enabled means nothing matches
// RULE9: software writes match only while inactive; match_q takes writes in any state
// RULE10: channel-set context uses shared 64-bit mask
// RULE11: channel-set needs stream fill and header; CHSET routes packets without FILL or HDR set
// RULE12: set addresses enable, clear addresses disable
// RULE13: mask reads show enabled channels as ones
// RULE14: mask survives bus reset, not hard reset
// RULE15: single-channel one packet per cycle; fill chains
// RULE16: stopped context drops queued packets
// RULE17: clearing run stops context at once
// RULE18: channel-set context wins shared channels
// RULE19: enables read back only implemented contexts
// RULE20: per-context flags gated, one summary bit
// RULE21: mismatch event suspends cycle-start matching
// RULE22: software stops armed contexts, clears event
// RULE23: run without arm goes active at once
module irm_ctx_match (
    input  wire logic                     CORE_CLK_I,
    input  wire logic                     NRST_I,
    // axi4-lite slave
    input  wire logic [`IRM_ADDR_W-1:0]   S_AXI_AWADDR_I,
    input  wire logic                     S_AXI_AWVALID_I,
    output logic                          S_AXI_AWREADY_O,
    input  wire logic [31:0]              S_AXI_WDATA_I,
    input  wire logic [3:0]               S_AXI_WSTRB_I,
    input  wire logic                     S_AXI_WVALID_I,
    output logic                          S_AXI_WREADY_O,
    output logic [1:0]                    S_AXI_BRESP_O,
    output logic                          S_AXI_BVALID_O,
    input  wire logic                     S_AXI_BREADY_I,
    input  wire logic [`IRM_ADDR_W-1:0]   S_AXI_ARADDR_I,
    input  wire logic                     S_AXI_ARVALID_I,
    output logic                          S_AXI_ARREADY_O,
    output logic [31:0]                   S_AXI_RDATA_O,
    output logic [1:0]                    S_AXI_RRESP_O,
    output logic                          S_AXI_RVALID_O,
    input  wire logic                     S_AXI_RREADY_I,
    // cycle timer
    input  wire logic                     CYCLE_START_I,
    input  wire logic [1:0]               BUS_SECONDS_FIELD_I,
    input  wire logic [12:0]              BUS_CYCLE_NUMBER_I,
    input  wire logic                     CYCLE_CLOCK_MISMATCH_I,
    // receive fifo head
    input  wire logic                     PKT_VALID_I,
    input  wire logic [5:0]               PKT_CHANNEL_I,
    input  wire logic [1:0]               PKT_LABEL_I,
    input  wire logic [3:0]               PKT_SYNC_I,
    // descriptor processing
    input  wire logic [2*`IRM_NCTX-1:0]   DESC_HOLD_CODE_I,
    input  wire logic [`IRM_NCTX-1:0]     PROGRAM_END_I,
    input  wire logic [`IRM_NCTX-1:0]     CTX_IRQ_REQ_I,
    output logic                          PKT_ACCEPT_O,
    output logic                          PKT_DROP_O,
    output logic [`IRM_CTX_IDX_W-1:0]     PKT_CTX_O,
    output logic                          PKT_CHAIN_O,
    output logic                          PKT_KEEP_HEADER_O,
    output logic [`IRM_NCTX-1:0]          CTX_ACTIVE_O
);

    localparam int N = `IRM_NCTX;

    ////////////////////////////////////////////////////////////////////////
    // bus slave front end

    logic                   aw_hold_q;
    logic [`IRM_ADDR_W-1:0] aw_addr_q;
    logic                   w_hold_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    logic                   wr_fire;
    logic [31:0]            wr_bmask;
    logic [31:0]            wr_ones;

    assign S_AXI_AWREADY_O = !aw_hold_q && !bvalid_q;
    assign S_AXI_WREADY_O  = !w_hold_q && !bvalid_q;
    assign S_AXI_ARREADY_O = !rvalid_q;
    assign S_AXI_BVALID_O  = bvalid_q;
    assign S_AXI_BRESP_O   = bresp_q;
    assign S_AXI_RVALID_O  = rvalid_q;
    assign S_AXI_RDATA_O   = rdata_q;
    assign S_AXI_RRESP_O   = rresp_q;

    // write commits once both halves are parked
    assign wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                       {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wr_ones  = w_data_q & wr_bmask;

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR_I;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            w_hold_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_hold_q <= 1'b1;
            w_data_q <= S_AXI_WDATA_I;
            w_strb_q <= S_AXI_WSTRB_I;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end
    end

    function automatic logic addr_mapped(
        input logic [`IRM_ADDR_W-1:0] a
    );
        logic ok;
        ok = (a[7:6] == `IRM_CTX_WIN) && (a[3] == 1'b0);
        case (a)
            `IRM_MASK_HI_SET, `IRM_MASK_HI_CLR,
            `IRM_MASK_LO_SET, `IRM_MASK_LO_CLR,
            `IRM_IRQ_FLAGS, `IRM_IRQ_ENABLES,
            `IRM_TOP_FLAGS: ok = 1'b1;
            default: ;
        endcase
        return ok && (a[1:0] == 2'b00);
    endfunction

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `IRM_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_mapped(aw_addr_q) ? `IRM_RESP_OKAY
                                               : `IRM_RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            bvalid_q <= 1'b0;
        end
    end

    logic wr_ctx_win;
    logic [`IRM_CTX_IDX_W-1:0] wr_ctx;
    assign wr_ctx_win = wr_fire && (aw_addr_q[7:6] == `IRM_CTX_WIN);
    assign wr_ctx     = aw_addr_q[5:4];

    ////////////////////////////////////////////////////////////////////////
    // shared channel mask: no reset, so a bus reset leaves it alone

    logic [63:0] chan_mask_q;

    always_ff @(posedge CORE_CLK_I) begin
        if (wr_fire) begin
            case (aw_addr_q)
                `IRM_MASK_HI_SET:
                    chan_mask_q[63:32] <= chan_mask_q[63:32] | wr_ones; //RULE12
                `IRM_MASK_HI_CLR:
                    chan_mask_q[63:32] <= chan_mask_q[63:32] & ~wr_ones; //RULE12
                `IRM_MASK_LO_SET:
                    chan_mask_q[31:0] <= chan_mask_q[31:0] | wr_ones; //RULE12
                `IRM_MASK_LO_CLR:
                    chan_mask_q[31:0] <= chan_mask_q[31:0] & ~wr_ones; //RULE12
                default: ;
            endcase
        end
    end
    // RULE14 is met by leaving chan_mask_q outside NRST_I

    ////////////////////////////////////////////////////////////////////////
    // cycle-start matching suspension and interrupt flags

    logic            mismatch_q;
    logic [N-1:0]    irq_flags_q;
    logic [N-1:0]    irq_en_q;
    logic            rx_summary;
    logic            cyc_ok;
    irm_pkg::irm_cycle_t now_cycle;

    assign now_cycle  = {BUS_SECONDS_FIELD_I, BUS_CYCLE_NUMBER_I}; //RULE5
    assign cyc_ok     = CYCLE_START_I && !mismatch_q; //RULE21
    assign rx_summary = |(irq_flags_q & irq_en_q); //RULE20

    // set wins over a software clear in the same cycle
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            mismatch_q <= 1'b0;
        end else if (CYCLE_CLOCK_MISMATCH_I) begin
            mismatch_q <= 1'b1;
        end else if (wr_fire && aw_addr_q == `IRM_TOP_FLAGS &&
                     wr_ones[`IRM_T_MISMATCH]) begin
            mismatch_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_flags_q <= '0;
        end else if (wr_fire && aw_addr_q == `IRM_IRQ_FLAGS) begin
            irq_flags_q <= (irq_flags_q & ~wr_ones[N-1:0])
                           | CTX_IRQ_REQ_I; //RULE20
        end else begin
            irq_flags_q <= irq_flags_q | CTX_IRQ_REQ_I; //RULE20
        end
    end

    // only implemented contexts have enable storage
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            irq_en_q <= '0;
        end else if (wr_fire && aw_addr_q == `IRM_IRQ_ENABLES) begin
            irq_en_q <= (irq_en_q & ~wr_bmask[N-1:0])
                        | (w_data_q[N-1:0] & wr_bmask[N-1:0]); //RULE19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-context control, start sequencing and packet filter

    logic [4:0]           ctl_q   [N];
    logic [31:0]          match_q [N];
    irm_pkg::irm_ctx_state_e st_q [N];
    logic [N-1:0]         took_q;
    logic [N-1:0]         hit_single;
    logic [N-1:0]         hit_set;
    logic [N-1:0]         sync_miss;
    logic [N-1:0]         act;

    assign CTX_ACTIVE_O = act;

    for (genvar i = 0; i < N; i++) begin : g_ctx
        logic wr_ctl;
        logic wr_match;
        logic run;
        logic arm;
        logic label_ok;
        logic [3:0] label_en;
        logic hold_sync;
        logic cyc_hit;

        assign wr_ctl   = wr_ctx_win && wr_ctx == i
                          && aw_addr_q[3:2] == `IRM_CTX_CONTROL;
        assign wr_match = wr_ctx_win && wr_ctx == i
                          && aw_addr_q[3:2] == `IRM_CTX_MATCH;
        assign run      = ctl_q[i][`IRM_C_RUN];
        assign arm      = ctl_q[i][`IRM_C_ARM];
        assign act[i]   = (st_q[i] == irm_pkg::IRM_ACTIVE);
        assign cyc_hit  = st_q[i] == irm_pkg::IRM_ARMED && run && arm
                          && cyc_ok
                          && now_cycle == match_q[i][`IRM_M_CMP]; //RULE6
        // label enable bit k admits label code k; all zero admits none
        assign label_en = match_q[i][`IRM_M_LABEL];
        assign label_ok = label_en[PKT_LABEL_I]; //RULE1 RULE8
        assign hold_sync = DESC_HOLD_CODE_I[2*i +: 2] == `IRM_HOLD_SYNC;
        // sync mismatch only discards while holding
        assign sync_miss[i] = hold_sync
                   && PKT_SYNC_I != match_q[i][`IRM_M_SYNC]; //RULE2 RULE4
        assign hit_set[i] = act[i] && ctl_q[i][`IRM_C_CHSET]
                   && chan_mask_q[PKT_CHANNEL_I] && label_ok //RULE10
                   && !sync_miss[i]; //RULE3
        assign hit_single[i] = act[i] && !ctl_q[i][`IRM_C_CHSET]
                   && PKT_CHANNEL_I == match_q[i][`IRM_M_CHAN] //RULE7
                   && label_ok && !sync_miss[i] //RULE2 RULE3
                   && !took_q[i]; //RULE15

        // software write wins the data bits; hardware only drops arm and run
        always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                ctl_q[i] <= `IRM_CTL_RST;
            end else if (wr_ctl) begin
                ctl_q[i] <= (ctl_q[i] & ~wr_bmask[4:0])
                            | (w_data_q[4:0] & wr_bmask[4:0]);
            end else begin
                if (cyc_hit) begin
                    ctl_q[i][`IRM_C_ARM] <= 1'b0; //RULE6
                end
                if (act[i] && PROGRAM_END_I[i]) begin
                    ctl_q[i][`IRM_C_RUN] <= 1'b0; //RULE16
                end
            end
        end

        always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                match_q[i] <= `IRM_MATCH_RST;
            end else if (wr_match) begin
                // unguarded: writes while active are the caller's hazard
                match_q[i] <= (match_q[i] & ~wr_bmask)
                              | (w_data_q & wr_bmask);
            end
        end

        always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                st_q[i] <= irm_pkg::IRM_IDLE;
            end else begin
                case (st_q[i])
                    irm_pkg::IRM_IDLE: begin
                        if (run && !arm) begin
                            st_q[i] <= irm_pkg::IRM_ACTIVE; //RULE23
                        end else if (run) begin
                            st_q[i] <= irm_pkg::IRM_ARMED;
                        end
                    end
                    irm_pkg::IRM_ARMED: begin
                        if (!run) begin
                            st_q[i] <= irm_pkg::IRM_IDLE;
                        end else if (!arm || cyc_hit) begin
                            st_q[i] <= irm_pkg::IRM_ACTIVE; //RULE6
                        end
                    end
                    irm_pkg::IRM_ACTIVE: begin
                        if (!run || PROGRAM_END_I[i]) begin
                            st_q[i] <= irm_pkg::IRM_IDLE; //RULE17
                        end
                    end
                    default: st_q[i] <= irm_pkg::IRM_IDLE;
                endcase
            end
        end

        // one packet per bus cycle for single-channel contexts
        always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                took_q[i] <= 1'b0;
            end else if (CYCLE_START_I) begin
                took_q[i] <= 1'b0; //RULE15
            end else if (PKT_VALID_I && PKT_ACCEPT_O
                         && PKT_CTX_O == i) begin
                took_q[i] <= 1'b1; //RULE15
            end
        end

        a_armed_waits: assert property ( //RULE6
            @(posedge CORE_CLK_I) disable iff (!NRST_I)
            st_q[i] == irm_pkg::IRM_ARMED && arm && !cyc_hit && run
            |=> st_q[i] != irm_pkg::IRM_ACTIVE)
            else $error("armed context went active without match");

        a_match_starts: assert property ( //RULE6
            @(posedge CORE_CLK_I) disable iff (!NRST_I)
            cyc_hit && !wr_ctl
            |=> act[i] && !ctl_q[i][`IRM_C_ARM])
            else $error("cycle match did not start context");

        a_mismatch_holds: assert property ( //RULE21
            @(posedge CORE_CLK_I) disable iff (!NRST_I)
            mismatch_q && st_q[i] == irm_pkg::IRM_ARMED && arm && run
            && !wr_ctl |=> st_q[i] == irm_pkg::IRM_ARMED)
            else $error("armed context started during mismatch");

        a_run_immediate: assert property ( //RULE23
            @(posedge CORE_CLK_I) disable iff (!NRST_I)
            st_q[i] == irm_pkg::IRM_IDLE && run && !arm
            |=> act[i])
            else $error("run without arm did not activate");

        a_stop_on_run: assert property ( //RULE17
            @(posedge CORE_CLK_I) disable iff (!NRST_I)
            act[i] && !run |=> !act[i])
            else $error("context still active after run cleared");
    end

    ////////////////////////////////////////////////////////////////////////
    // routing: channel-set context first, else lowest single context

    logic                       acc_d;
    logic [`IRM_CTX_IDX_W-1:0]  ctx_d;

    always_comb begin
        acc_d = 1'b0;
        ctx_d = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (hit_single[k]) begin
                acc_d = 1'b1;
                ctx_d = k[`IRM_CTX_IDX_W-1:0];
            end
        end
        for (int k = N - 1; k >= 0; k--) begin
            if (hit_set[k]) begin
                acc_d = 1'b1; //RULE18
                ctx_d = k[`IRM_CTX_IDX_W-1:0]; //RULE18
            end
        end
    end

    // decision is combinational so the fifo pops in the same cycle
    assign PKT_ACCEPT_O = PKT_VALID_I && acc_d;
    assign PKT_DROP_O   = PKT_VALID_I && !acc_d; //RULE16 RULE4
    assign PKT_CTX_O    = ctx_d;

    // chaining and header keeping follow the chosen context
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PKT_CHAIN_O       <= 1'b0;
            PKT_KEEP_HEADER_O <= 1'b0;
        end else if (PKT_ACCEPT_O) begin
            PKT_CHAIN_O       <= ctl_q[ctx_d][`IRM_C_FILL]; //RULE15
            PKT_KEEP_HEADER_O <= ctl_q[ctx_d][`IRM_C_HDR];
        end
    end

    a_set_wins: assert property ( //RULE18
        @(posedge CORE_CLK_I) disable iff (!NRST_I)
        PKT_VALID_I && |hit_set |-> PKT_ACCEPT_O && hit_set[PKT_CTX_O])
        else $error("channel-set context lost a shared packet");

    a_no_idle_accept: assert property ( //RULE16
        @(posedge CORE_CLK_I) disable iff (!NRST_I)
        PKT_ACCEPT_O |-> act[PKT_CTX_O])
        else $error("packet routed to a stopped context");

    ////////////////////////////////////////////////////////////////////////
    // register read side

    logic [31:0] rd_d;

    always_comb begin
        rd_d = '0;
        case (S_AXI_ARADDR_I)
            `IRM_MASK_HI_SET, `IRM_MASK_HI_CLR:
                rd_d = chan_mask_q[63:32]; //RULE13
            `IRM_MASK_LO_SET, `IRM_MASK_LO_CLR:
                rd_d = chan_mask_q[31:0]; //RULE13
            `IRM_IRQ_FLAGS:   rd_d[N-1:0] = irq_flags_q;
            `IRM_IRQ_ENABLES: rd_d[N-1:0] = irq_en_q; //RULE19
            `IRM_TOP_FLAGS: begin
                rd_d[`IRM_T_RX_SUM]   = rx_summary; //RULE20
                rd_d[`IRM_T_MISMATCH] = mismatch_q;
            end
            default: begin
                if (S_AXI_ARADDR_I[7:6] == `IRM_CTX_WIN) begin
                    if (S_AXI_ARADDR_I[3:2] == `IRM_CTX_CONTROL) begin
                        rd_d[4:0] = ctl_q[S_AXI_ARADDR_I[5:4]];
                        rd_d[`IRM_C_ACTIVE] = act[S_AXI_ARADDR_I[5:4]];
                    end else if (S_AXI_ARADDR_I[3:2] == `IRM_CTX_MATCH) begin
                        rd_d = match_q[S_AXI_ARADDR_I[5:4]];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= `IRM_RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_q <= 1'b1;
            rdata_q  <= addr_mapped(S_AXI_ARADDR_I) ? rd_d : '0;
            rresp_q  <= addr_mapped(S_AXI_ARADDR_I) ? `IRM_RESP_OKAY
                                                    : `IRM_RESP_SLVERR;
        end else if (S_AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
        end
    end

    a_summary_bit: assert property ( //RULE20
        @(posedge CORE_CLK_I) disable iff (!NRST_I)
        CTX_IRQ_REQ_I[0] && irq_en_q[0] ##1 irq_en_q[0]
        |-> rx_summary)
        else $error("summary bit missing for enabled context event");

endmodule

// ===== testbench/irm_link_model.sv
`timescale 1ns/100ps
// fifo head and cycle timer; stale fields go inverted so nothing looks valid
module irm_link_model (
    input  wire logic        clk_i,
    input  wire logic        pop_i,
    input  wire logic [2:0]  take_i,
    output logic             cyc_start_o,
    output logic [14:0]      cyc_time_o,
    output logic             pkt_valid_o,
    output logic [11:0]      pkt_hdr_o
);
    initial begin
        cyc_start_o = 1'b0;
        cyc_time_o = 15'h0000;
        pkt_valid_o = 1'b0;
        pkt_hdr_o = 12'h000;
    end
    task automatic tick(input logic [14:0] t);
        cyc_start_o <= 1'b1;
        cyc_time_o <= t;
        @(posedge clk_i);
        cyc_start_o <= 1'b0;
        cyc_time_o <= ~t;
        @(posedge clk_i);
    endtask
    // header held until popped; result is {accept, context}
    task automatic send(input logic [11:0] h, output logic [2:0] res);
        pkt_valid_o <= 1'b1;
        pkt_hdr_o <= h;
        do @(posedge clk_i); while (pop_i !== 1'b1);
        res = take_i;
        pkt_valid_o <= 1'b0;
        pkt_hdr_o <= ~h;
        @(posedge clk_i);
    endtask
endmodule

// ===== testbench/irm_ctx_match_tb.sv
`timescale 1ns/100ps
module irm_ctx_match_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  aw = 8'h00;
    logic [7:0]  ar = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rd;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [4:0]  vr = 5'h00;
    logic [2:0]  rdy;
    logic        bv;
    logic        rv;
    logic        cs;
    logic        mm = 1'b0;
    logic        pv;
    logic        pa;
    logic        pd;
    logic        chain;
    logic        keep;
    logic [1:0]  pctx;
    logic [14:0] ct;
    logic [11:0] hdr;
    logic [7:0]  hold = 8'h00;
    logic [3:0]  pend = 4'h0;
    logic [3:0]  irq = 4'h0;
    logic [3:0]  act;
    int          bad_count = 0;
    int          comparisons = 0;
    always #10 clk = ~clk;
    irm_link_model irm_link_model_inst (.clk_i(clk), .pop_i(pa | pd),
        .take_i({pa, pctx}), .cyc_start_o(cs), .cyc_time_o(ct),
        .pkt_valid_o(pv), .pkt_hdr_o(hdr));
    irm_ctx_match irm_ctx_match_inst (.CORE_CLK_I(clk), .NRST_I(nrst),
        .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(vr[0]),
        .S_AXI_AWREADY_O(rdy[0]), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
        .S_AXI_WVALID_I(vr[1]), .S_AXI_WREADY_O(rdy[1]),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(vr[2]),
        .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(vr[3]),
        .S_AXI_ARREADY_O(rdy[2]), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(vr[4]), .CYCLE_START_I(cs),
        .BUS_SECONDS_FIELD_I(ct[14:13]), .BUS_CYCLE_NUMBER_I(ct[12:0]),
        .CYCLE_CLOCK_MISMATCH_I(mm), .PKT_VALID_I(pv),
        .PKT_CHANNEL_I(hdr[11:6]), .PKT_LABEL_I(hdr[5:4]),
        .PKT_SYNC_I(hdr[3:0]), .DESC_HOLD_CODE_I(hold),
        .PROGRAM_END_I(pend), .CTX_IRQ_REQ_I(irq), .PKT_ACCEPT_O(pa),
        .PKT_DROP_O(pd), .PKT_CTX_O(pctx), .PKT_CHAIN_O(chain),
        .PKT_KEEP_HEADER_O(keep), .CTX_ACTIVE_O(act));
////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aw <= a;
        wd <= d;
        vr[2:0] <= 3'b111;
        do begin
            @(posedge clk);
            if (rdy[0]) vr[0] <= 1'b0;
            if (rdy[1]) vr[1] <= 1'b0;
        end while (bv !== 1'b1);
        chk({30'h0, bresp}, 32'h0);
    endtask
    // 8'h1c is left unmapped on purpose
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ar <= a;
        vr[4:3] <= 2'b11;
        do begin
            @(posedge clk);
            if (rdy[2]) vr[3] <= 1'b0;
        end while (rv !== 1'b1);
        chk(rd, e);
        chk({30'h0, rresp}, {30'h0, a == 8'h1c, 1'b0});
    endtask
    task automatic pk(input logic [5:0] c, input logic [1:0] l,
                      input logic [3:0] s, input logic [2:0] e);
        logic [2:0] got;
        irm_link_model_inst.send({c, l, s}, got);
        chk({29'h0, got[2], got[1:0] & {2{got[2]}}}, {29'h0, e});
    endtask
    task automatic tk(input logic [14:0] t);
        irm_link_model_inst.tick(t);
    endtask
    task automatic settle_act(input logic [3:0] e);
        repeat (2) @(posedge clk);
        chk({28'h0, act}, {28'h0, e});
    endtask
    task automatic t_regs;
        wr(8'h14, 32'hffff_ffff);
        rdc(8'h14, 32'h0000_000f);
        rdc(8'h44, 32'h0000_0000);
        rdc(8'h1c, 32'h0000_0000);
        wr(8'h04, 32'hffff_ffff);
        wr(8'h00, 32'hffff_ffff);
        wr(8'h04, 32'h0000_ffff);
        rdc(8'h00, 32'hffff_0000);
        wr(8'h0c, 32'hffff_ffff);
        wr(8'h08, 32'h0000_0020);
        rdc(8'h0c, 32'h0000_0020);
    endtask
    task automatic t_single;
        int l;
        wr(8'h44, 32'h5000_0905);
        wr(8'h54, 32'h0000_0007);
        wr(8'h40, 32'h0000_0001);
        wr(8'h50, 32'h0000_0001);
        settle_act(4'h3);
        for (l = 0; l < 4; l++) begin
            tk(15'h0001);
            pk(6'd5, l[1:0], 4'h0, l[0] ? 3'b000 : 3'b100);
        end
        tk(15'h0002);
        pk(6'd5, 2'd0, 4'h0, 3'b100);
        chk({30'h0, chain, keep}, 32'h0000_0000);
        pk(6'd5, 2'd0, 4'h0, 3'b000);
        pk(6'd6, 2'd0, 4'h0, 3'b000);
        pk(6'd7, 2'd0, 4'h0, 3'b000);
        hold <= 8'h03;
        tk(15'h0003);
        pk(6'd5, 2'd0, 4'h3, 3'b000);
        pk(6'd5, 2'd0, 4'h9, 3'b100);
        hold <= 8'h00;
    endtask
    task automatic t_stop;
        wr(8'h40, 32'h0000_0000);
        tk(15'h0004);
        pk(6'd5, 2'd0, 4'h9, 3'b000);
        wr(8'h40, 32'h0000_0001);
        pend <= 4'h1;
        @(posedge clk);
        pend <= 4'h0;
        rdc(8'h40, 32'h0000_0000);
        wr(8'h40, 32'h0000_0001);
    endtask
    task automatic t_chset;
        wr(8'h64, 32'hf000_0000);
        wr(8'h60, 32'h0000_001d);
        tk(15'h0005);
        pk(6'd5, 2'd0, 4'h0, 3'b110);
        chk({30'h0, chain, keep}, 32'h0000_0003);
        pk(6'd5, 2'd3, 4'h0, 3'b110);
        pk(6'd6, 2'd0, 4'h0, 3'b000);
        settle_act(4'h7);
    endtask
    task automatic t_arm;
        wr(8'h74, 32'hf412_3009);
        wr(8'h70, 32'h0000_0003);
        tk(15'h0123);
        tk(15'h4122);
        settle_act(4'h7);
        mm <= 1'b1;
        @(posedge clk);
        mm <= 1'b0;
        tk(15'h4123);
        settle_act(4'h7);
        rdc(8'h18, 32'h0000_0002);
        wr(8'h70, 32'h0000_0000);
        rdc(8'h70, 32'h0000_0000);
        wr(8'h18, 32'h0000_0002);
        wr(8'h70, 32'h0000_0003);
        tk(15'h4123);
        settle_act(4'hf);
        rdc(8'h70, 32'h0000_0101);
    endtask
    task automatic t_irq;
        irq <= 4'h1;
        @(posedge clk);
        irq <= 4'h0;
        rdc(8'h10, 32'h0000_0001);
        rdc(8'h18, 32'h0000_0001);
        wr(8'h14, 32'h0000_0002);
        rdc(8'h18, 32'h0000_0000);
        wr(8'h10, 32'h0000_0001);
        rdc(8'h10, 32'h0000_0000);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs;
        t_single;
        t_stop;
        t_chset;
        t_arm;
        t_irq;
        wrap_up;
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        wrap_up;
    end
endmodule
